/* rtl/power_mgmt_cfg.svh */
// constants of the power controller: offsets, fields, timing
// assumes a 40 MHz pclk and 32-bit APB data
`ifndef POWER_MGMT_CFG_SVH
`define POWER_MGMT_CFG_SVH

`define PM_CLK_HZ 64'd40000000
`define PM_QUICK_LIMIT_S 64'd28800
`define PM_QUICK_LIMIT_CYC (`PM_QUICK_LIMIT_S * `PM_CLK_HZ)

`define PM_ADDR_CTRL 12'h000
`define PM_ADDR_STATUS 12'h004
`define PM_ADDR_IRQ_STAT 12'h008
`define PM_ADDR_IRQ_MASK 12'h00C
`define PM_ADDR_ERROR 12'h010
`define PM_ADDR_THRESH 12'h014
`define PM_ADDR_BATT_ADC 12'h018
`define PM_ADDR_GAUGE 12'h01C
`define PM_ADDR_INFO 12'h020

`define PM_CTRL_RESET 8'h01
`define PM_THRESH_RESET 32'h0320_0080

`define PM_IRQ_LOW 0
`define PM_IRQ_ERR 1
`define PM_IRQ_FULL 2
`define PM_IRQ_NEWBATT 3
`define PM_IRQ_SEQ 4
`define PM_IRQ_W 5

`define PM_ERR_NONE 8'h00
`define PM_ERR_VOLT 8'h01
`define PM_ERR_TEMP 8'h02
`define PM_ERR_SMBUS 8'h03
`define PM_ERR_CELL 8'h04
`define PM_ERR_TIMEOUT 8'h05

`define PM_LVL_WARN_PCT 7'd10
`define PM_LVL_CRIT_PCT 7'd3
`define PM_LVL_SUSP_PCT 7'd1

`endif

/* rtl/power_mgmt_pkg.sv */
// types of the power controller
// assumes power_mgmt_cfg.svh holds the numbers
package power_mgmt_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'hF,
        SEQ_0    = 4'h0,
        SEQ_1    = 4'h1,
        SEQ_2    = 4'h3,
        SEQ_3    = 4'h2,
        SEQ_4    = 4'h6,
        SEQ_ON   = 4'h7,
        SEQ_5    = 4'h5,
        SEQ_6    = 4'h4,
        SEQ_7    = 4'hC,
        SEQ_8    = 4'hD,
        SEQ_9    = 4'h9,
        SEQ_A    = 4'h8,
        SEQ_B    = 4'hA
    } seq_state_t;

    typedef enum logic [1:0] {
        CHG_OFF    = 2'b00,
        CHG_NORMAL = 2'b01,
        CHG_QUICK  = 2'b11
    } charge_mode_t;

    typedef enum logic [2:0] {
        LVL_OK       = 3'd0,
        LVL_WARN     = 3'd1,
        LVL_CRITICAL = 3'd2,
        LVL_SUSPEND  = 3'd3,
        LVL_DEAD     = 3'd4
    } batt_level_t;

endpackage

/* rtl/power_mgmt_controller.sv */
// power management controller: battery sense, charging, sequencing, leds
// assumes synchronous inputs; adc and smbus agents hand over
// samples and gauge words with one-cycle valid strobes
//
// Contract
// R1: 10-bit voltage and temperature samples drive battery decisions.
// R2: battery presence from the voltage sample, adapter from a digital input.
// R3: an abnormal condition writes its code into the error register.
// R4: system and direct disc power levels are watched at all times.
// R5: the beeper sounds while the battery is classed as low.
// R6: the adapter led is blue while the adapter is present.
// R7: battery led blue when full, orange when quick charging or low; the code holds blue off while low.
// R8: power on steps through states 0 to 4, power off through 5 to B.
// R9: gauge percentage gives four low levels: warn, critical, suspend, dead.
// R10: a newly inserted battery triggers a read of its stored information.
// R11: remaining and percentage capacity come from the smbus gauge words.
// R12: charging and full detection act only with adapter and battery.
// R13: quick charge while the system is off, normal while it runs.
// R14: quick charge ends unconditionally after eight hours.
// R15: quick charge stops on full, removal, bad volt or temp, smbus or cell.
// R16: full charge is learned from status the pack reports over smbus.
// R17: the quick charge timer starts at zero and clears when charging stops.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "power_mgmt_cfg.svh"

module power_mgmt_controller #(
    parameter int          ADC_W       = 10,
    parameter logic [63:0] QUICK_LIMIT = 64'(`PM_QUICK_LIMIT_CYC)
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [ADC_W-1:0]  batt_volt_sample,
    input  wire logic [ADC_W-1:0]  batt_temp_sample,
    input  wire logic              sample_valid,
    input  wire logic              adapter_sense,
    input  wire logic              sys_power_on,
    input  wire logic              disc_power_on,
    input  wire logic [15:0]       gauge_remaining,
    input  wire logic [6:0]        gauge_percent,
    input  wire logic              gauge_full,
    input  wire logic              gauge_bad_cell,
    input  wire logic              gauge_valid,
    input  wire logic              smbus_fail,
    input  wire logic [15:0]       info_word,
    input  wire logic              info_valid,
    output logic                   info_read_req,
    output logic                   beeper,
    output logic                   adapter_led_blue,
    output logic                   batt_led_blue,
    output logic                   batt_led_orange,
    output logic                   charge_enable,
    output logic                   charge_quick,
    output logic [3:0]             seq_step,
    output logic                   irq
);

    // --
    // register and sensing state
    // --
    logic [7:0]                   ctrl;
    logic [31:0]                  thresh;
    logic [`PM_IRQ_W-1:0]         irq_stat;
    logic [`PM_IRQ_W-1:0]         irq_mask;
    logic [`PM_IRQ_W-1:0]         irq_event;
    logic [7:0]                   error_code;
    logic [ADC_W-1:0]             volt_q;
    logic [ADC_W-1:0]             temp_q;
    logic [15:0]                  remaining_q;
    logic [6:0]                   percent_q;
    logic                         full_q;
    logic [15:0]                  info_q;
    logic                         batt_present;
    logic                         batt_present_d;
    logic                         sys_on_q;
    logic                         disc_on_q;
    logic                         power_on_req;
    logic                         power_on_d;
    logic [63:0]                  quick_timer;
    logic                         quick_expired;
    logic                         stop_quick;
    logic                         volt_bad;
    logic                         temp_bad;
    logic                         ac_and_batt;
    logic                         is_low;
    power_mgmt_pkg::batt_level_t  level;
    power_mgmt_pkg::seq_state_t   seq;
    power_mgmt_pkg::seq_state_t   next_seq;
    power_mgmt_pkg::charge_mode_t mode;
    power_mgmt_pkg::charge_mode_t next_mode;
    logic                         wr_en;
    logic                         rd_en;
    logic [31:0]                  next_prdata;
    logic                         next_pslverr;

    // --
    // sampling of analog values and input levels
    // --
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_q <= '0;
            temp_q <= '0;
        end else if (sample_valid) begin
            volt_q <= batt_volt_sample; // R1
            temp_q <= batt_temp_sample; // R1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_on_q  <= 1'b0;
            disc_on_q <= 1'b0;
        end else begin
            sys_on_q  <= sys_power_on; // R4
            disc_on_q <= disc_power_on; // R4
        end
    end

    // battery fitted above the presence floor
    assign batt_present = volt_q > thresh[ADC_W-1:0]; // R2
    assign volt_bad     = batt_present && (volt_q == {ADC_W{1'b1}});
    assign temp_bad     = temp_q > thresh[16 +: ADC_W]; // R1
    assign ac_and_batt  = adapter_sense && batt_present; // R2 R12
    assign power_on_req = (sys_on_q || disc_on_q) && ctrl[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining_q <= '0;
            percent_q   <= 7'd100;
            full_q      <= 1'b0;
        end else if (!batt_present) begin
            full_q <= 1'b0;
        end else if (gauge_valid) begin
            remaining_q <= gauge_remaining; // R11
            percent_q   <= gauge_percent; // R11
            full_q      <= gauge_full && ac_and_batt; // R16 R12
        end
    end

    // --
    // low battery levels
    // --
    always_comb begin
        if (!batt_present) begin
            level = power_mgmt_pkg::LVL_OK;
        end else if (percent_q == 7'd0) begin
            level = power_mgmt_pkg::LVL_DEAD; // R9
        end else if (percent_q <= `PM_LVL_SUSP_PCT) begin
            level = power_mgmt_pkg::LVL_SUSPEND; // R9
        end else if (percent_q <= `PM_LVL_CRIT_PCT) begin
            level = power_mgmt_pkg::LVL_CRITICAL; // R9
        end else if (percent_q <= `PM_LVL_WARN_PCT) begin
            level = power_mgmt_pkg::LVL_WARN; // R9
        end else begin
            level = power_mgmt_pkg::LVL_OK;
        end
    end
    assign is_low = level != power_mgmt_pkg::LVL_OK;

    // --
    // new battery information read
    // --
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            batt_present_d <= 1'b0;
            info_read_req  <= 1'b0;
            info_q         <= '0;
        end else begin
            batt_present_d <= batt_present;
            if (batt_present && !batt_present_d) begin
                info_read_req <= 1'b1; // R10
            end else if (info_valid || !batt_present) begin
                info_read_req <= 1'b0;
            end
            if (info_valid) begin
                info_q <= info_word; // R10
            end
        end
    end

    // --
    // charging control
    // --
    assign quick_expired = quick_timer >= QUICK_LIMIT - 64'd1;
    assign stop_quick    = full_q || !ac_and_batt || volt_bad // R15
                        || temp_bad || smbus_fail || gauge_bad_cell
                        || quick_expired; // R14

    always_comb begin
        next_mode = mode;
        if (!ac_and_batt || full_q || !ctrl[1]
            || error_code != `PM_ERR_NONE) begin
            next_mode = power_mgmt_pkg::CHG_OFF; // R12 R15 R14
        end else if (mode == power_mgmt_pkg::CHG_QUICK
                     && (stop_quick || sys_on_q)) begin
            next_mode = power_mgmt_pkg::CHG_OFF; // R15 R13
        end else if (mode == power_mgmt_pkg::CHG_OFF) begin
            if (volt_bad || temp_bad || smbus_fail || gauge_bad_cell) begin
                next_mode = power_mgmt_pkg::CHG_OFF;
            end else if (sys_on_q) begin
                next_mode = power_mgmt_pkg::CHG_NORMAL; // R13
            end else begin
                next_mode = power_mgmt_pkg::CHG_QUICK; // R13
            end
        end else if (mode == power_mgmt_pkg::CHG_NORMAL && !sys_on_q) begin
            next_mode = power_mgmt_pkg::CHG_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= power_mgmt_pkg::CHG_OFF;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quick_timer <= '0;
        end else if (mode != power_mgmt_pkg::CHG_QUICK) begin
            quick_timer <= '0; // R17
        end else begin
            quick_timer <= quick_timer + 64'd1; // R14
        end
    end

    // --
    // error capture
    // --
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_code <= `PM_ERR_NONE;
        end else if (volt_bad) begin
            error_code <= `PM_ERR_VOLT; // R3
        end else if (temp_bad) begin
            error_code <= `PM_ERR_TEMP; // R3
        end else if (smbus_fail) begin
            error_code <= `PM_ERR_SMBUS; // R3
        end else if (gauge_bad_cell) begin
            error_code <= `PM_ERR_CELL; // R3
        end else if (mode == power_mgmt_pkg::CHG_QUICK && quick_expired) begin
            error_code <= `PM_ERR_TIMEOUT; // R3
        end else if (wr_en && paddr == `PM_ADDR_ERROR) begin
            error_code <= `PM_ERR_NONE;
        end
    end

    // --
    // power on and off sequence
    // --
    always_comb begin
        next_seq = seq;
        case (seq)
            power_mgmt_pkg::SEQ_IDLE: begin
                if (power_on_req) begin
                    next_seq = power_mgmt_pkg::SEQ_0; // R8
                end
            end
            power_mgmt_pkg::SEQ_0: next_seq = power_mgmt_pkg::SEQ_1;
            power_mgmt_pkg::SEQ_1: next_seq = power_mgmt_pkg::SEQ_2;
            power_mgmt_pkg::SEQ_2: next_seq = power_mgmt_pkg::SEQ_3;
            power_mgmt_pkg::SEQ_3: next_seq = power_mgmt_pkg::SEQ_4;
            power_mgmt_pkg::SEQ_4: next_seq = power_mgmt_pkg::SEQ_ON;
            power_mgmt_pkg::SEQ_ON: begin
                if (!power_on_req) begin
                    next_seq = power_mgmt_pkg::SEQ_5; // R8
                end
            end
            power_mgmt_pkg::SEQ_5: next_seq = power_mgmt_pkg::SEQ_6;
            power_mgmt_pkg::SEQ_6: next_seq = power_mgmt_pkg::SEQ_7;
            power_mgmt_pkg::SEQ_7: next_seq = power_mgmt_pkg::SEQ_8;
            power_mgmt_pkg::SEQ_8: next_seq = power_mgmt_pkg::SEQ_9;
            power_mgmt_pkg::SEQ_9: next_seq = power_mgmt_pkg::SEQ_A;
            power_mgmt_pkg::SEQ_A: next_seq = power_mgmt_pkg::SEQ_B;
            power_mgmt_pkg::SEQ_B: next_seq = power_mgmt_pkg::SEQ_IDLE;
            default:               next_seq = power_mgmt_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq        <= power_mgmt_pkg::SEQ_IDLE;
            power_on_d <= 1'b0;
        end else begin
            seq        <= next_seq;
            power_on_d <= power_on_req;
        end
    end

    // --
    // outputs: leds, beeper, charger, step number
    // --
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beeper           <= 1'b0;
            adapter_led_blue <= 1'b0;
            batt_led_blue    <= 1'b0;
            batt_led_orange  <= 1'b0;
            charge_enable    <= 1'b0;
            charge_quick     <= 1'b0;
            seq_step         <= 4'hF;
        end else begin
            beeper           <= is_low && ctrl[2]; // R5
            adapter_led_blue <= adapter_sense; // R6
            batt_led_orange  <= (mode == power_mgmt_pkg::CHG_QUICK)
                             || is_low; // R7
            batt_led_blue    <= full_q && !is_low; // R7
            charge_enable    <= mode != power_mgmt_pkg::CHG_OFF;
            charge_quick     <= mode == power_mgmt_pkg::CHG_QUICK; // R13
            seq_step         <= seq; // R8
        end
    end

    // --
    // interrupts
    // --
    assign irq_event[`PM_IRQ_LOW]     = is_low && (percent_q != 7'd100)
                                     && gauge_valid;
    assign irq_event[`PM_IRQ_ERR]     = volt_bad || temp_bad || smbus_fail
                                     || gauge_bad_cell;
    assign irq_event[`PM_IRQ_FULL]    = full_q && !irq_stat[`PM_IRQ_FULL]
                                     && gauge_valid;
    assign irq_event[`PM_IRQ_NEWBATT] = batt_present && !batt_present_d;
    assign irq_event[`PM_IRQ_SEQ]     = power_on_req != power_on_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq      <= 1'b0;
        end else begin
            if (wr_en && paddr == `PM_ADDR_IRQ_MASK) begin
                irq_mask <= pwdata[`PM_IRQ_W-1:0];
            end
            if (wr_en && paddr == `PM_ADDR_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[`PM_IRQ_W-1:0]) | irq_event;
            end else begin
                irq_stat <= irq_stat | irq_event;
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // --
    // apb slave
    // --
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (paddr == `PM_ADDR_CTRL) begin
            next_prdata = {24'h00_0000, ctrl};
        end else if (paddr == `PM_ADDR_STATUS) begin
            next_prdata = {16'h0000, 2'b00, mode, seq, 1'b0, level,
                           sys_on_q, disc_on_q, adapter_sense,
                           batt_present};
        end else if (paddr == `PM_ADDR_IRQ_STAT) begin
            next_prdata = {27'h000_0000, irq_stat};
        end else if (paddr == `PM_ADDR_IRQ_MASK) begin
            next_prdata = {27'h000_0000, irq_mask};
        end else if (paddr == `PM_ADDR_ERROR) begin
            next_prdata = {24'h00_0000, error_code};
        end else if (paddr == `PM_ADDR_THRESH) begin
            next_prdata = thresh;
        end else if (paddr == `PM_ADDR_BATT_ADC) begin
            next_prdata = {6'h00, temp_q, 6'h00, volt_q};
        end else if (paddr == `PM_ADDR_GAUGE) begin
            next_prdata = {8'h00, full_q, percent_q, remaining_q};
        end else if (paddr == `PM_ADDR_INFO) begin
            next_prdata = {16'h0000, info_q};
        end else begin
            next_pslverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && next_pslverr;
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= `PM_CTRL_RESET;
            thresh <= `PM_THRESH_RESET;
        end else if (wr_en && paddr == `PM_ADDR_CTRL) begin
            ctrl <= pwdata[7:0];
        end else if (wr_en && paddr == `PM_ADDR_THRESH) begin
            thresh <= pwdata;
        end
    end

endmodule

/* tb/pm_props.sv */
// checker on the power controller ports
// bound to every power_mgmt_controller instance
`timescale 1ns/1ps
module pm_props #(
    parameter logic [63:0] QUICK_LIMIT = 64'd50
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       adapter_sense,
    input wire logic       sys_power_on,
    input wire logic       beeper,
    input wire logic       adapter_led_blue,
    input wire logic       batt_led_blue,
    input wire logic       batt_led_orange,
    input wire logic       charge_enable,
    input wire logic       charge_quick,
    input wire logic [3:0] seq_step
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [63:0] qcnt;
    // quick charge length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            qcnt <= 64'h0;
        else
            qcnt <= charge_quick ? qcnt + 64'h1 : 64'h0;
    end
    AST_APB_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_ADAPTER_LED: assert property ($past(presetn) |->
        adapter_led_blue == $past(adapter_sense)) else $error("ac led");
    AST_QUICK_ORANGE: assert property (charge_quick |->
        batt_led_orange && charge_enable) else $error("quick led");
    AST_BEEP_LOW: assert property (beeper |->
        batt_led_orange && !batt_led_blue) else $error("beep led");
    AST_QUICK_SYS: assert property (sys_power_on [*4] |->
        !charge_quick) else $error("quick while on");
    AST_NO_ADAPTER: assert property (!adapter_sense [*3] |->
        !charge_enable) else $error("charge without adapter");
    AST_QUICK_LIMIT: assert property (qcnt <= QUICK_LIMIT + 64'h2)
        else $error("quick charge too long");
    AST_SEQ_UP: assert property ($changed(seq_step) && seq_step == 4'h7
        |-> $past(seq_step) == 4'h6) else $error("power up order");
    AST_SEQ_DOWN: assert property ($changed(seq_step) && seq_step == 4'hF
        |-> $past(seq_step) == 4'hA) else $error("power down order");
endmodule
bind power_mgmt_controller pm_props #(.QUICK_LIMIT(QUICK_LIMIT)) u_pm_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .adapter_sense(adapter_sense),
    .sys_power_on(sys_power_on), .beeper(beeper),
    .adapter_led_blue(adapter_led_blue), .batt_led_blue(batt_led_blue),
    .batt_led_orange(batt_led_orange), .charge_enable(charge_enable),
    .charge_quick(charge_quick), .seq_step(seq_step));

/* tb/battery_pack_model.sv */
// smart battery model: gauge words and stored information
// percent, full and answer speed set by the bench
`timescale 1ns/1ps
module battery_pack_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [6:0]  pct,
    input  wire logic        full,
    input  wire logic        slow,
    input  wire logic        info_read_req,
    output logic      [15:0] gauge_remaining,
    output logic      [6:0]  gauge_percent,
    output logic             gauge_full,
    output logic             gauge_valid,
    output logic      [15:0] info_word,
    output logic             info_valid
);
    logic [3:0] tick;
    logic [3:0] wt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tick, wt, gauge_valid, info_valid} <= 10'h000;
        end else begin
            tick <= tick + 4'h1;
            gauge_valid <= (tick == 4'h7);
            wt <= (info_read_req && !info_valid) ? wt + 4'h1 : 4'h0;
            info_valid <= (wt == (slow ? 4'h6 : 4'h2));
        end
    end
    // words valid with strobe, inverted otherwise
    assign gauge_percent   = gauge_valid ? pct : ~pct;
    assign gauge_remaining = gauge_valid ? {pct, 9'h000} : ~{pct, 9'h000};
    assign gauge_full      = gauge_valid ? full : ~full;
    assign info_word       = info_valid ? 16'h5A3C : 16'hA5C3;
endmodule

/* tb/testbench.sv */
// self-checking bench for the power controller
// pack model on the gauge side, bench drives adc and sense levels
`timescale 1ns/1ps
module testbench;
    localparam logic [63:0] QL = 64'd200;
    logic        pclk = 1'b0, presetn = 1'b0, sv = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [9:0]  volt = 10'h000, temp = 10'h000;
    logic        ac = 1'b0, sys = 1'b0, full = 1'b0, bad = 1'b0, fail = 1'b0;
    logic [6:0]  pct = 7'd100, gpct;
    logic [6:0]  pcts [5] = '{7'd50, 7'd10, 7'd3, 7'd1, 7'd0};
    logic [15:0] grem, iword;
    logic        pready, pslverr, gfull, gv, iv, ireq, beep, lac, lb, lo;
    logic        chg_en, chg_q, irq;
    logic [3:0]  seq;
    logic [64:0] notes [$];
    logic [64:0] nt;
    int          seed = 32'hC3D2, checked = 0, mismatches = 0, i;
    always #12.5 pclk = ~pclk;
    power_mgmt_controller #(.QUICK_LIMIT(QL)) u_power_mgmt_controller (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .batt_volt_sample(volt),
        .batt_temp_sample(temp), .sample_valid(sv), .adapter_sense(ac),
        .sys_power_on(sys), .disc_power_on(1'b0), .gauge_remaining(grem),
        .gauge_percent(gpct), .gauge_full(gfull), .gauge_bad_cell(bad),
        .gauge_valid(gv), .smbus_fail(fail), .info_word(iword),
        .info_valid(iv), .info_read_req(ireq), .beeper(beep),
        .adapter_led_blue(lac), .batt_led_blue(lb), .batt_led_orange(lo),
        .charge_enable(chg_en), .charge_quick(chg_q), .seq_step(seq),
        .irq(irq));
    battery_pack_model u_battery_pack_model (
        .pclk(pclk), .presetn(presetn), .pct(pct), .full(full), .slow(1'b1),
        .info_read_req(ireq), .gauge_remaining(grem), .gauge_percent(gpct),
        .gauge_full(gfull), .gauge_valid(gv), .info_word(iword),
        .info_valid(iv));
    task automatic cmp(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
                      input logic err);
        notes.push_back({m, e, err});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic smp(input logic [9:0] v, t);
        @(posedge pclk);
        {volt, temp, sv} <= {v, t, 1'b1};
        @(posedge pclk);
        sv <= 1'b0;
    endtask
    task automatic wseq(input logic [3:0] v);
        for (i = 0; i < 40 && seq !== v; i++)
            @(negedge pclk);
        cmp("seq_step", 32'(v), 32'(seq));
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // compare reads with oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            nt = notes.pop_front();
            cmp("prdata", nt[32:1], prdata & nt[64:33]);
            cmp("pslverr", 32'(nt[0]), 32'(pslverr));
        end
    end
    // run takes about 850 cycles
    initial begin
        #500000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'hFF, 32'h1, 1'b0);
        rd(12'h014, 32'hFFFFFFFF, 32'h0320_0080, 1'b0);
        rd(12'h040, 32'hFFFFFFFF, 32'h0, 1'b1);
        r = $random(seed) & 32'h1F;
        apb(1'b1, 12'h00C, r);
        rd(12'h00C, 32'h1F, r, 1'b0);
        apb(1'b1, 12'h00C, 32'h2);
        apb(1'b1, 12'h000, 32'h7);
        {ac, sys} <= 2'b11;
        smp(10'h100 | 10'($random(seed) & 32'hFF), 10'h100);
        repeat (20) @(negedge pclk);
        rd(12'h020, 32'hFFFF, 32'h5A3C, 1'b0);
        wseq(4'h7);
        cmp("charge_quick", 32'h0, 32'(chg_q));
        cmp("charge_enable", 32'h1, 32'(chg_en));
        @(posedge pclk);
        sys <= 1'b0;
        wseq(4'hF);
        repeat (3) @(negedge pclk);
        cmp("charge_quick", 32'h1, 32'(chg_q));
        @(posedge pclk);
        full <= 1'b1;
        repeat (40) @(negedge pclk);
        cmp("charge_quick", 32'h0, 32'(chg_q));
        cmp("batt_led_blue", 32'h1, 32'(lb));
        @(posedge pclk);
        full <= 1'b0;
        repeat (240) @(negedge pclk);
        cmp("charge_quick", 32'h0, 32'(chg_q));
        rd(12'h010, 32'hFF, 32'h5, 1'b0);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'h1F);
        for (int k = 1; k <= 4; k++) begin
            repeat (4) @(negedge pclk);
            cmp("charge_quick", 32'h1, 32'(chg_q));
            @(posedge pclk);
            {fail, bad} <= {k == 3, k == 4};
            smp(k == 1 ? 10'h3FF : 10'h100, k == 2 ? 10'h3FF : 10'h100);
            repeat (40) @(negedge pclk);
            cmp("charge_quick", 32'h0, 32'(chg_q));
            cmp("irq", 32'h1, 32'(irq));
            rd(12'h010, 32'hFF, 32'(k), 1'b0);
            if (k == 1) begin
                apb(1'b1, 12'h00C, 32'h0);
                repeat (3) @(negedge pclk);
                cmp("irq", 32'h0, 32'(irq));
                apb(1'b1, 12'h00C, 32'h2);
            end
            smp(10'h100, 10'h100);
            {fail, bad} <= 2'b00;
            apb(1'b1, 12'h010, 32'h0);
            apb(1'b1, 12'h008, 32'h1F);
            repeat (3) @(negedge pclk);
            cmp("irq", 32'h0, 32'(irq));
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge pclk);
            {pct, sys} <= {pcts[k], 1'b1};
            repeat (40) @(negedge pclk);
            cmp("beeper", 32'(k != 0), 32'(beep));
            rd(12'h004, 32'h70, 32'(k) << 4, 1'b0);
        end
        cmp("adapter_led_blue", 32'h1, 32'(lac));
        cmp("charge_enable", 32'h1, 32'(chg_en));
        @(posedge pclk);
        ac <= 1'b0;
        repeat (5) @(negedge pclk);
        cmp("adapter_led_blue", 32'h0, 32'(lac));
        cmp("charge_enable", 32'h0, 32'(chg_en));
        print_verdict();
    end
endmodule
